// File: core/plcr_pkg.sv
// Purpose: shared constants and types for the loop configuration register bank
// Assumes: word-indexed registers, byte address is four times the index
// Notes:   reset values of the counter and control registers are fixed here
package plcr_pkg;

   // register indices and the bus address width
   localparam logic [9:0]  IDX_RZERO   = 10'h01d;
   localparam logic [9:0]  IDX_CP_CUR  = 10'h0f0;
   localparam logic [9:0]  IDX_FB      = 10'h0f1;
   localparam logic [9:0]  IDX_CTRL    = 10'h0f2;
   localparam logic [9:0]  IDX_STATUS  = 10'h0ff;
   localparam int          ADDR_W      = 12;

   // values after reset
   localparam logic [7:0]  RST_RZERO   = 8'h00;
   localparam logic [7:0]  RST_CP_CUR  = 8'h00;
   localparam logic [7:0]  RST_FB      = 8'h04;
   localparam logic [7:0]  RST_CTRL    = 8'h0b;

   // field positions
   localparam int          RZ_W        = 4;
   localparam int          CTRL_LDPD   = 7;
   localparam int          CTRL_RSV    = 6;
   localparam int          CTRL_DBL    = 5;
   localparam int          CTRL_ABEN   = 4;
   localparam int          CTRL_ABW    = 2;
   localparam int          CTRL_CPM    = 0;
   localparam int          FB_A        = 6;
   localparam int          FB_B_W      = 6;
   localparam int          ST_ILLEGAL  = 8;
   localparam int          ST_ABW      = 9;

   // zero-resistor codes
   localparam logic [3:0]  RZ_LOWEST   = 4'h4;
   localparam logic [3:0]  RZ_EXT      = 4'h8;
   localparam logic [2:0]  RZ_SEL_LOW  = 3'h4;

   // counter pair limits
   localparam logic [5:0]  B_MIN       = 6'h04;
   localparam logic [5:0]  B_FULL_A    = 6'h07;

   typedef enum logic [1:0] {
      ABW_MIN  = 2'b00,
      ABW_LOW  = 2'b01,
      ABW_HIGH = 2'b10,
      ABW_MAX  = 2'b11
   } plcr_abw_t;

   typedef enum logic [1:0] {
      CPM_TRI    = 2'b00,
      CPM_UP     = 2'b01,
      CPM_DOWN   = 2'b10,
      CPM_NORMAL = 2'b11
   } plcr_cpm_t;

   typedef enum logic [3:0] {
      BUS_IDLE = 4'b0001,
      BUS_WR   = 4'b0010,
      BUS_RD   = 4'b0100,
      BUS_RDY  = 4'b1000
   } plcr_bus_st_t;

endpackage : plcr_pkg

// File: core/plcr_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the loop configuration registers
// Assumes: single word transfers, one slave on the bus
// Notes:   writes take no wait state, reads take one so a preceding write is seen
`timescale 1ns/1ps
module plcr_ahb_slave (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          arst_n,
   // ahb-lite
   input  wire logic                          hsel,
   input  wire logic [plcr_pkg::ADDR_W-1:0]   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic [31:0]                        hrdata,
   // register side
   output logic                               wr_en,
   output logic [9:0]                         reg_idx,
   input  wire logic [31:0]                   rd_data
);

   plcr_pkg::plcr_bus_st_t state;
   plcr_pkg::plcr_bus_st_t next_state;
   logic                   take;

   assign take      = hsel && htrans[1] && hready;
   assign hreadyout = (state != plcr_pkg::BUS_RD);
   assign wr_en     = (state == plcr_pkg::BUS_WR);

   always_comb begin
      case (state)
         plcr_pkg::BUS_RD: begin
            next_state = plcr_pkg::BUS_RDY;
         end
         plcr_pkg::BUS_IDLE, plcr_pkg::BUS_WR, plcr_pkg::BUS_RDY: begin
            if (take) begin
               next_state = hwrite ? plcr_pkg::BUS_WR : plcr_pkg::BUS_RD;
            end else begin
               next_state = plcr_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_state = plcr_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state <= plcr_pkg::BUS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // address held through the data phase
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_idx <= 10'h000;
      end else if (take) begin
         reg_idx <= haddr[plcr_pkg::ADDR_W-1:2];
      end
   end

   // sampled after the wait cycle, so a write just before is already stored
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (state == plcr_pkg::BUS_RD) begin
         hrdata <= rd_data;
      end
   end

   a_read_one_wait: assert property (@(posedge mclk) disable iff (!arst_n)
      (take && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");

endmodule : plcr_ahb_slave

// File: core/plcr_regs.sv
// Purpose: loop configuration register bank with decoded analog controls
// Assumes: AHB-Lite master, mclk 100 MHz, asynchronous active-low reset
// Notes:   fields drive analog trims through one register stage; no field is self-clearing
`timescale 1ns/1ps

// Contract
// RULE1: four-bit zero resistor code, external at 1000
// RULE2: eight-bit pump current magnitude field
// RULE3: feedback ratio is four B plus A
// RULE4: software keeps A and B pair legal
// RULE5: bit 7 set powers down lock detector
// RULE6: software writes zero to bit 6
// RULE7: bit 5 set doubles output loop reference
// RULE8: bit 4 clear forces antibacklash high
// RULE9: software should set bit 4
// RULE10: antibacklash codes min low high max
// RULE11: pump mode tristate up down normal
// RULE12: fields hold and read back last write
module plcr_regs (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          arst_n,
   // ahb-lite slave
   input  wire logic                          hsel,
   input  wire logic [plcr_pkg::ADDR_W-1:0]   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic [31:0]                        hrdata,
   output logic                               hresp,
   // first loop filter
   output logic [2:0]                         rzero_step,
   output logic                               rzero_external,
   // output loop charge pump
   output logic [7:0]                         pump_current,
   output logic                               pump_tristate,
   output logic                               pump_up,
   output logic                               pump_down,
   output logic                               pump_normal,
   // output loop feedback and control
   output logic [7:0]                         feedback_ratio,
   output logic                               counters_illegal,
   output logic                               lock_det_powerdown,
   output logic                               ref_doubler_en,
   output logic [1:0]                         antibacklash_width
);

   logic [7:0]  rzero_reg;
   logic [7:0]  cp_cur_reg;
   logic [7:0]  fb_reg;
   logic [7:0]  ctrl_reg;
   logic        wr_en;
   logic [9:0]  reg_idx;
   logic [31:0] rd_data;
   logic [1:0]  abw_eff;
   logic        ratio_bad;

   // ------------------------------------------------------------ helpers
   function automatic logic [7:0] fb_ratio(input logic [7:0] fb);
      fb_ratio = {fb[plcr_pkg::FB_B_W-1:0], 2'b00} + {6'h00, fb[7:plcr_pkg::FB_A]};
   endfunction : fb_ratio

   // true when the A/B pair falls outside the allowed table
   function automatic logic fb_illegal(input logic [7:0] fb);
      logic [5:0] b;
      logic [1:0] a;
      b = fb[plcr_pkg::FB_B_W-1:0];
      a = fb[7:plcr_pkg::FB_A];
      if (b < plcr_pkg::B_MIN) begin
         fb_illegal = 1'b1;
      end else if (b == plcr_pkg::B_MIN) begin
         fb_illegal = (a > 2'd1);
      end else if (b < plcr_pkg::B_FULL_A) begin
         fb_illegal = (a > 2'd2);
      end else begin
         fb_illegal = 1'b0;
      end
   endfunction : fb_illegal

   function automatic logic [1:0] abw_of(input logic [7:0] ctrl);
      if (ctrl[plcr_pkg::CTRL_ABEN]) begin
         abw_of = ctrl[plcr_pkg::CTRL_ABW +: 2];
      end else begin
         abw_of = plcr_pkg::ABW_HIGH;
      end
   endfunction : abw_of

   // ------------------------------------------------------------ bus front end
   plcr_ahb_slave u_bus (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .wr_en     (wr_en),
      .reg_idx   (reg_idx),
      .rd_data   (rd_data)
   );

   // only single word transfers exist on this bus, so hsize is not decoded
   assign hresp = 1'b0;

   // ------------------------------------------------------------ storage
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rzero_reg <= plcr_pkg::RST_RZERO;
      end else if (wr_en && reg_idx == plcr_pkg::IDX_RZERO) begin
         rzero_reg <= {4'h0, hwdata[plcr_pkg::RZ_W-1:0]}; // RULE1 RULE12
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cp_cur_reg <= plcr_pkg::RST_CP_CUR;
      end else if (wr_en && reg_idx == plcr_pkg::IDX_CP_CUR) begin
         cp_cur_reg <= hwdata[7:0]; // RULE2 RULE12
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fb_reg <= plcr_pkg::RST_FB;
      end else if (wr_en && reg_idx == plcr_pkg::IDX_FB) begin
         fb_reg <= hwdata[7:0]; // RULE3 RULE12
      end
   end

   // the reserved bit is stored as written so software can see a bad write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= plcr_pkg::RST_CTRL;
      end else if (wr_en && reg_idx == plcr_pkg::IDX_CTRL) begin
         ctrl_reg <= hwdata[7:0]; // RULE12
      end
   end

   // ------------------------------------------------------------ read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      case (reg_idx)
         plcr_pkg::IDX_RZERO: begin
            rd_data = {24'h000000, rzero_reg};
         end
         plcr_pkg::IDX_CP_CUR: begin
            rd_data = {24'h000000, cp_cur_reg};
         end
         plcr_pkg::IDX_FB: begin
            rd_data = {24'h000000, fb_reg};
         end
         plcr_pkg::IDX_CTRL: begin
            rd_data = {24'h000000, ctrl_reg};
         end
         plcr_pkg::IDX_STATUS: begin
            rd_data = {21'h000000, abw_eff, ratio_bad, fb_ratio(fb_reg)};
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // ------------------------------------------------------------ decoded controls
   assign abw_eff   = abw_of(ctrl_reg); // RULE8
   assign ratio_bad = fb_illegal(fb_reg); // RULE4

   // codes above the external one are unused; they fall back to the lowest step
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rzero_step     <= 3'h0;
         rzero_external <= 1'b0;
      end else begin
         rzero_external <= (rzero_reg[3:0] == plcr_pkg::RZ_EXT); // RULE1
         if (rzero_reg[3:0] < plcr_pkg::RZ_LOWEST) begin
            rzero_step <= rzero_reg[2:0]; // RULE1
         end else begin
            rzero_step <= plcr_pkg::RZ_SEL_LOW; // RULE1
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pump_current   <= 8'h00;
         feedback_ratio <= 8'h00;
         counters_illegal <= 1'b0;
      end else begin
         pump_current     <= cp_cur_reg; // RULE2
         feedback_ratio   <= fb_ratio(fb_reg); // RULE3
         counters_illegal <= ratio_bad; // RULE4
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lock_det_powerdown <= 1'b0;
         ref_doubler_en     <= 1'b0;
         antibacklash_width <= 2'b00;
      end else begin
         lock_det_powerdown <= ctrl_reg[plcr_pkg::CTRL_LDPD]; // RULE5
         ref_doubler_en     <= ctrl_reg[plcr_pkg::CTRL_DBL]; // RULE7
         antibacklash_width <= abw_eff; // RULE8 RULE10
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pump_tristate <= 1'b0;
         pump_up       <= 1'b0;
         pump_down     <= 1'b0;
         pump_normal   <= 1'b0;
      end else begin
         pump_tristate <= (ctrl_reg[plcr_pkg::CTRL_CPM +: 2] == plcr_pkg::CPM_TRI); // RULE11
         pump_up       <= (ctrl_reg[plcr_pkg::CTRL_CPM +: 2] == plcr_pkg::CPM_UP); // RULE11
         pump_down     <= (ctrl_reg[plcr_pkg::CTRL_CPM +: 2] == plcr_pkg::CPM_DOWN); // RULE11
         pump_normal   <= (ctrl_reg[plcr_pkg::CTRL_CPM +: 2] == plcr_pkg::CPM_NORMAL); // RULE11
      end
   end

   // ------------------------------------------------------------ checks
   sequence s_ctrl_wr;
      wr_en && reg_idx == plcr_pkg::IDX_CTRL;
   endsequence

   sequence s_fb_wr;
      wr_en && reg_idx == plcr_pkg::IDX_FB;
   endsequence

   sequence s_rz_wr;
      wr_en && reg_idx == plcr_pkg::IDX_RZERO;
   endsequence

   a_rzero_ext_sel: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
      s_rz_wr ##0 (hwdata[3:0] == 4'h8) |=> ##1 (rzero_external && rzero_step == 3'h4))
      else $error("external zero resistor code not decoded");

   a_rzero_low_step: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
      s_rz_wr ##0 (hwdata[3:2] == 2'b01) |=> ##1 (rzero_step == 3'h4 && !rzero_external))
      else $error("codes 4 to 7 must select the lowest step");

   a_pump_current: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
      (wr_en && reg_idx == plcr_pkg::IDX_CP_CUR) |=> ##1 (pump_current == $past(hwdata[7:0], 2)))
      else $error("pump current does not follow its write");

   a_fb_ratio_calc: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
      s_fb_wr |=> ##1 (feedback_ratio == 8'(4 * $past(hwdata[5:0], 2) + $past(hwdata[7:6], 2))))
      else $error("feedback ratio is not four B plus A");

   a_fb_illegal_flag: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
      s_fb_wr ##0 (hwdata[7:0] == 8'h84) |=> ##1 counters_illegal)
      else $error("A of two with B of four not flagged");

   a_lock_det_pd: assert property (@(posedge mclk) disable iff (!arst_n) // RULE5
      s_ctrl_wr |=> ##1 (lock_det_powerdown == $past(hwdata[7], 2)))
      else $error("lock detector power-down not following bit 7");

   a_doubler_en: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
      s_ctrl_wr |=> ##1 (ref_doubler_en == $past(hwdata[5], 2)))
      else $error("doubler enable not following bit 5");

   a_abw_forced_high: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
      s_ctrl_wr ##0 !hwdata[4] |=> ##1 (antibacklash_width == 2'b10)[*2])
      else $error("antibacklash not forced high with bit 4 clear");

   a_abw_field_use: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
      s_ctrl_wr ##0 hwdata[4] |=> ##1 (antibacklash_width == $past(hwdata[3:2], 2)))
      else $error("antibacklash field not applied with bit 4 set");

   a_pump_mode_onehot: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
      s_ctrl_wr |=> ##1 ($onehot({pump_tristate, pump_up, pump_down, pump_normal})
                         && (pump_normal == ($past(hwdata[1:0], 2) == 2'b11))
                         && (pump_up == ($past(hwdata[1:0], 2) == 2'b01))))
      else $error("pump mode decode wrong");

   a_regs_hold: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
      !wr_en |=> ($stable(ctrl_reg) && $stable(fb_reg) && $stable(cp_cur_reg) && $stable(rzero_reg)))
      else $error("register changed without a write");

   a_readback_ctrl: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
      (hreadyout && reg_idx == plcr_pkg::IDX_CTRL && $past(u_bus.state) == plcr_pkg::BUS_RD)
      |-> (hrdata == {24'h000000, ctrl_reg}))
      else $error("control register read back differs");

   a_rzero_int_step: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
      s_rz_wr ##0 (hwdata[3:2] == 2'b00) |=> ##1 (rzero_step == $past(hwdata[2:0], 2) && !rzero_external))
      else $error("internal zero resistor code not decoded");

   a_fb_low_b: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
      s_fb_wr ##0 (hwdata[5:0] < 6'h04) |=> ##1 counters_illegal)
      else $error("B below four not flagged");

   a_fb_legal_pair: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
      s_fb_wr ##0 (hwdata[5:0] >= 6'h07) |=> ##1 !counters_illegal)
      else $error("legal counter pair flagged");

   a_pump_tri_down: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
      s_ctrl_wr |=> ##1 ((pump_tristate == ($past(hwdata[1:0], 2) == 2'b00))
                         && (pump_down == ($past(hwdata[1:0], 2) == 2'b10))))
      else $error("pump tristate or down decode wrong");

endmodule : plcr_regs

// File: testbench/tb.sv
// Purpose: self-checking bench for the loop configuration register bank
// Assumes: ahb-lite master in the bench, one wait state on reads, outputs lag the register by one cycle
// Notes:   reads are noted in a queue by the driver and checked by a separate bus monitor
`timescale 1ns/1ps
module tb;
   logic                         mclk;
   logic                         arst_n;
   logic                         hsel;
   logic [plcr_pkg::ADDR_W-1:0]  haddr;
   logic [1:0]                   htrans;
   logic                         hwrite;
   logic [2:0]                   hsize;
   logic [31:0]                  hwdata;
   logic                         hready;
   logic                         hreadyout;
   logic [31:0]                  hrdata;
   logic                         hresp;
   logic [2:0]                   rzero_step;
   logic                         rzero_external;
   logic [7:0]                   pump_current;
   logic                         pump_tristate;
   logic                         pump_up;
   logic                         pump_down;
   logic                         pump_normal;
   logic [7:0]                   feedback_ratio;
   logic                         counters_illegal;
   logic                         lock_det_powerdown;
   logic                         ref_doubler_en;
   logic [1:0]                   antibacklash_width;
   logic [7:0]                   s_rz, s_cur, s_fb, s_ctrl;
   logic                         rd_pend;
   logic [31:0]                  q_exp[$];
   string                        q_name[$];
   int                           num_errors;
   int                           samples_checked;
   logic [7:0]                   fb_tab[8] = '{8'h04, 8'h44, 8'h84, 8'h85, 8'hc6, 8'hc7, 8'h03, 8'hff};
   localparam logic [11:0]       A_RZ = {plcr_pkg::IDX_RZERO, 2'b00};
   localparam logic [11:0]       A_CUR = {plcr_pkg::IDX_CP_CUR, 2'b00};
   localparam logic [11:0]       A_FB = {plcr_pkg::IDX_FB, 2'b00};
   localparam logic [11:0]       A_CTRL = {plcr_pkg::IDX_CTRL, 2'b00};
   localparam logic [11:0]       A_ST = {plcr_pkg::IDX_STATUS, 2'b00};

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   plcr_regs dut (
      .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .rzero_step(rzero_step), .rzero_external(rzero_external),
      .pump_current(pump_current), .pump_tristate(pump_tristate), .pump_up(pump_up),
      .pump_down(pump_down), .pump_normal(pump_normal), .feedback_ratio(feedback_ratio),
      .counters_illegal(counters_illegal), .lock_det_powerdown(lock_det_powerdown),
      .ref_doubler_en(ref_doubler_en), .antibacklash_width(antibacklash_width)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   // status image: width, illegal flag, ratio
   function automatic logic [10:0] exp_status;
      logic [5:0] b;
      logic [1:0] a;
      logic       ill;
      b = s_fb[5:0];
      a = s_fb[7:6];
      ill = (b < 6'd4) || (b == 6'd4 && a > 2'd1) || (b < 6'd7 && a > 2'd2);
      return {(s_ctrl[4] ? s_ctrl[3:2] : 2'b10), ill, {b, 2'b00} + {6'h00, a}};
   endfunction : exp_status

   task automatic bus_wait;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         $display("BAD bus wait expected ready seen timeout");
         num_errors++;
         end_sim();
      end
   endtask : bus_wait

   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      // every request is launched right at a rising edge
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      bus_wait();
      htrans <= 2'b00;
      hwdata <= d;
      bus_wait();
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'($urandom_range(32'h00ff_ffff, 0)), d});
      case (a)
         A_RZ: s_rz = {4'h0, d[3:0]};
         A_CUR: s_cur = d;
         A_FB: s_fb = d;
         A_CTRL: s_ctrl = d;
         default: ;
      endcase
      @(posedge mclk);
      #1;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      q_exp.push_back(e);
      q_name.push_back(nm);
      bus(1'b0, a, $urandom);
   endtask : rd

   task automatic rd_all;
      rd(A_RZ, {24'h0, s_rz}, "rzero reg");
      rd(A_CUR, {24'h0, s_cur}, "pump current reg");
      rd(A_FB, {24'h0, s_fb}, "counters reg");
      rd(A_CTRL, {24'h0, s_ctrl}, "control reg");
      rd(A_ST, {21'h0, exp_status()}, "status reg");
   endtask : rd_all

   task automatic chk_all;
      logic [10:0] st;
      st = exp_status();
      if (s_rz != 8'h08) chk("rzero_step", (s_rz < 8'h04) ? s_rz : 8'h04, rzero_step);
      chk("rzero_external", s_rz == 8'h08, rzero_external);
      chk("pump_current", s_cur, pump_current);
      chk("pump mode", 4'b0001 << s_ctrl[1:0], {pump_normal, pump_down, pump_up, pump_tristate});
      chk("feedback_ratio", st[7:0], feedback_ratio);
      chk("counters_illegal", st[8], counters_illegal);
      chk("lock_det_powerdown", s_ctrl[7], lock_det_powerdown);
      chk("ref_doubler_en", s_ctrl[5], ref_doubler_en);
      chk("antibacklash_width", st[10:9], antibacklash_width);
   endtask : chk_all

   task automatic shadow_reset;
      s_rz = plcr_pkg::RST_RZERO;
      s_cur = plcr_pkg::RST_CP_CUR;
      s_fb = plcr_pkg::RST_FB;
      s_ctrl = 8'h0b;
   endtask : shadow_reset

   // bus monitor: a read completes at the edge where ready returns high
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pend <= 1'b0;
      end else begin
         if (rd_pend && hreadyout === 1'b1) begin
            rd_pend <= 1'b0;
            if (q_exp.size() == 0) chk("read queue", 32'h1, 32'h0);
            else chk(q_name.pop_front(), q_exp.pop_front(), hrdata);
            chk("hresp", 32'h0, {31'h0, hresp});
         end
         if (hsel && htrans[1] && !hwrite && hready) rd_pend <= 1'b1;
      end
   end

   initial begin
      num_errors = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      void'($urandom(32'h63bf00c6));
      shadow_reset();
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      #1;
      chk_all();
      rd_all();
      for (int c = 0; c <= 15; c++) begin
         wr(A_RZ, {4'($urandom_range(15, 0)), c[3:0]});
         chk_all();
         rd(A_RZ, {24'h0, s_rz}, "rzero reg");
      end
      for (int i = 0; i < 6; i++) begin
         wr(A_CUR, 8'((i == 0) ? 8'hff : (i == 1) ? 8'h00 : $urandom_range(255, 0)));
         chk_all();
      end
      for (int i = 0; i < 14; i++) begin
         // software keeps the pair legal, but odd pairs must still be flagged
         wr(A_FB, (i < 8) ? fb_tab[i] : {2'($urandom_range(3, 0)), 6'($urandom_range(63, 7))});
         chk_all();
         rd_all();
      end
      for (int i = 0; i < 256; i++) begin
         wr(A_CTRL, i[7:0] & 8'hbf);
         chk_all();
         rd_all();
      end
      wr(12'h3f8, 8'h5a);
      rd(12'h3f8, 32'h0, "unmapped reg");
      rd(12'h000, 32'h0, "unmapped reg");
      wr(A_ST, 8'h00);
      rd_all();
      chk_all();
      @(posedge mclk);
      arst_n <= 1'b0;
      #1;
      chk("ratio in reset", 32'h0, {24'h0, feedback_ratio});
      chk("pump_normal in reset", 32'h0, {31'h0, pump_normal});
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      shadow_reset();
      @(posedge mclk);
      #1;
      chk_all();
      rd_all();
      repeat (4) @(posedge mclk);
      chk("reads left", 32'h0, q_exp.size());
      end_sim();
   end
endmodule : tb
